// ===== rtl/batch_params.svh
// Offsets, field positions, reset values and timing counts of the batch sequence controller.
// Included by bare name from the controller and the bench; holds definitions only.
// How it works
// - Assigned permit input low to start, run
// - Permit lost while running halts, outputs off
// - Start begins new batch or resumes
// - Start with permit high rewinds, no run
// - Pause input low suspends, outputs off
// - Pause input released resumes at once
// - Host pause suspends until next start
// - Any halt source halts at current step
// - Rewind halts and returns to first step
// - Pins, host commands, keys act alike
// - Unassigned permit counts as always active
// - Sequencing only in manual batching mode
// - Up to twenty steps, fixed order
// - Step output active until condition met
// - Pause step waits start; delay counts tenths
`ifndef BATCH_PARAMS_SVH
`define BATCH_PARAMS_SVH

`define CTRL_OFS          8'h00
`define CMD_OFS           8'h04
`define COUNT_OFS         8'h08
`define STATUS_OFS        8'h0c
`define OUTS_OFS          8'h10
`define STEP_OFS          8'h40

`define CTRL_MANUAL_BIT   0
`define CTRL_PERMIT_BIT   1
`define CMD_START_BIT     0
`define CMD_PAUSE_BIT     1
`define CMD_HALT_BIT      2
`define CMD_REWIND_BIT    3
`define STEP_KIND_LSB     0
`define STEP_DELAY_LSB    16
`define STATUS_STEP_LSB   8

`define CTRL_RESET        2'h0
`define STEP_MAX          20
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define CLK_PERIOD_NS     5
`define TENTH_SEC_NS      100000000
`define TENTH_CYCLES      (`TENTH_SEC_NS / `CLK_PERIOD_NS)

`endif

// ===== rtl/batch_pkg.sv
// Types shared by the batch sequence controller files.
// Assumes nothing of its surroundings.
package batch_pkg;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_RUN       = 3'b001,
		ST_HOLD_PIN  = 3'b010,
		ST_HOLD_HOST = 3'b011,
		ST_HALTED    = 3'b100,
		ST_DONE      = 3'b101
	} run_state_t;

	typedef enum logic [1:0] {
		KIND_LEVEL = 2'b00,
		KIND_PAUSE = 2'b01,
		KIND_DELAY = 2'b10,
		KIND_SKIP  = 2'b11
	} step_kind_t;

endpackage : batch_pkg

// ===== rtl/input_sync.sv
// Three-stage synchroniser for active-low pins with a two-stage agreement filter.
// Assumes the pins idle high; after reset every output reads inactive (high).
module input_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] pin_n,
	output logic      [WIDTH-1:0] level_n
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// The first stage feeds only the second; a change counts once stages two and three agree.
	always_comb begin
		state_next       = state_reg;
		state_next.s1    = pin_n;
		state_next.s2    = state_reg.s1;
		state_next.s3    = state_reg.s2;
		state_next.level = (~(state_reg.s2 ^ state_reg.s3) & state_reg.s3) |
		                   ((state_reg.s2 ^ state_reg.s3) & state_reg.level);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level_n = state_reg.level;

endmodule : input_sync

// ===== rtl/tenth_tick.sv
// Divider that emits a one-cycle enable pulse every CYCLES clocks.
// Assumes clear is driven from flip-flops on the same clock.
module tenth_tick #(
	parameter int CYCLES = 20000000
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic clear,
	output logic      tick
);

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          tick;
	} tick_state_t;

	tick_state_t state_reg;
	tick_state_t state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.tick = 1'b0;
		if (clear) begin
			state_next.count = '0;
		end else if (state_reg.count == CW'(CYCLES - 1)) begin
			state_next.count = '0;
			state_next.tick  = 1'b1;
		end else begin
			state_next.count = state_reg.count + CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick = state_reg.tick;

endmodule : tenth_tick

// ===== rtl/batch_sequence_controller.sv
// Batch run control: walks up to STEPS steps in order under pin, key and host-command control.
// Assumes an AXI4-Lite master on aclk, active-low control pins from outside the clock domain,
// and an external evaluator that reports each step's condition on step_condition_met.
//
// Our own choices: register access over AXI4-Lite and the address map.
`include "batch_params.svh"

module batch_sequence_controller #(
	parameter int STEPS        = `STEP_MAX,
	parameter int ADDR_W       = 8,
	parameter int TENTH_CYCLES = `TENTH_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              run_permit_input_n,
	input  wire logic              start_request_input_n,
	input  wire logic              pause_hold_input_n,
	input  wire logic              halt_request_input_n,
	input  wire logic              rewind_request_input_n,
	input  wire logic              panel_start_key_n,
	input  wire logic              panel_halt_key_n,
	input  wire logic [STEPS-1:0]  step_condition_met,
	output logic [STEPS-1:0]       batch_outputs,
	output logic [2:0]             run_state
);

	localparam int SW = $clog2(STEPS);
	localparam int PINS = 7;

	typedef struct packed {
		logic                                aw_held;
		logic [ADDR_W-1:0]                   aw_addr;
		logic                                w_held;
		logic [31:0]                         w_data;
		logic [3:0]                          w_strb;
		logic                                bvalid;
		logic [1:0]                          bresp;
		logic                                rvalid;
		logic [31:0]                         rdata;
		logic [1:0]                          rresp;
		logic                                manual;
		logic                                permit_assigned;
		logic [SW-1:0]                       step_count;
		batch_pkg::step_kind_t [STEPS-1:0]   kinds;
		logic [STEPS-1:0][15:0]              delays;
		logic                                host_start;
		logic                                host_pause;
		logic                                host_halt;
		logic                                host_rewind;
		logic                                start_seen_n;
		logic                                key_seen_n;
		batch_pkg::run_state_t               run_state;
		logic [SW-1:0]                       step;
		logic [15:0]                         delay_count;
		logic [STEPS-1:0]                    outputs;
	} ctrl_state_t;

	ctrl_state_t state_reg;
	ctrl_state_t state_next;

	logic [PINS-1:0] sync_n;
	logic            tick;
	logic            tick_clear;

	input_sync #(
		.WIDTH (PINS)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_n   ({panel_halt_key_n, panel_start_key_n, rewind_request_input_n, halt_request_input_n,
		            pause_hold_input_n, start_request_input_n, run_permit_input_n}),
		.level_n (sync_n)
	);

	tenth_tick #(
		.CYCLES (TENTH_CYCLES)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (tick_clear),
		.tick    (tick)
	);

	function automatic logic [31:0] merge(input logic [31:0] old_d, input logic [31:0] new_d,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old_d;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_d[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic is_step(input logic [ADDR_W-1:0] addr);
		return (addr >= ADDR_W'(`STEP_OFS)) && (addr < ADDR_W'(`STEP_OFS + 4 * STEPS));
	endfunction : is_step

	function automatic logic [SW-1:0] step_index(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] rel;
		rel = addr - ADDR_W'(`STEP_OFS);
		return SW'(rel >> 2);
	endfunction : step_index

	logic                 permit_ok;
	logic                 start_req;
	logic                 halt_req;
	logic                 rewind_req;
	logic                 pause_pin;
	logic                 active;
	batch_pkg::step_kind_t cur_kind;

	always_comb begin
		permit_ok  = !state_reg.permit_assigned || !sync_n[0];
		start_req  = (state_reg.start_seen_n && !sync_n[1]) || (state_reg.key_seen_n && !sync_n[5]) ||
		             state_reg.host_start;
		halt_req   = !sync_n[3] || !sync_n[6] || state_reg.host_halt;
		rewind_req = !sync_n[4] || state_reg.host_rewind;
		pause_pin  = !sync_n[2];
		active     = (state_reg.run_state == batch_pkg::ST_RUN) ||
		             (state_reg.run_state == batch_pkg::ST_HOLD_PIN) ||
		             (state_reg.run_state == batch_pkg::ST_HOLD_HOST);
		cur_kind   = state_reg.kinds[state_reg.step];
		// A paused or halted delay restarts its current tenth on resume; the count of whole tenths is kept.
		tick_clear = !((state_reg.run_state == batch_pkg::ST_RUN) && (cur_kind == batch_pkg::KIND_DELAY));
	end

	logic             advance;
	logic [31:0]      wr_word;
	logic [31:0]      rd_word;
	logic             rd_ok;
	logic [SW-1:0]    wr_idx;
	logic [SW-1:0]    rd_idx;

	always_comb begin
		state_next              = state_reg;
		state_next.host_start   = 1'b0;
		state_next.host_pause   = 1'b0;
		state_next.host_halt    = 1'b0;
		state_next.host_rewind  = 1'b0;
		state_next.start_seen_n = sync_n[1];
		state_next.key_seen_n   = sync_n[5];
		advance                 = 1'b0;
		wr_word                 = '0;
		rd_word                 = '0;
		rd_ok                   = 1'b1;
		wr_idx                  = step_index(state_reg.aw_addr);
		rd_idx                  = step_index(araddr);

		// Write side: address and data are taken in either order, the response follows both.
		if (awvalid && !state_reg.aw_held) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = awaddr;
		end
		if (wvalid && !state_reg.w_held) begin
			state_next.w_held = 1'b1;
			state_next.w_data = wdata;
			state_next.w_strb = wstrb;
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			state_next.aw_held = 1'b0;
			state_next.w_held  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = `RESP_OKAY;
			if (state_reg.aw_addr[ADDR_W-1:2] == `CTRL_OFS >> 2) begin
				wr_word = merge({30'h0, state_reg.permit_assigned, state_reg.manual},
				                state_reg.w_data, state_reg.w_strb);
				state_next.manual          = wr_word[`CTRL_MANUAL_BIT];
				state_next.permit_assigned = wr_word[`CTRL_PERMIT_BIT];
			end else if (state_reg.aw_addr[ADDR_W-1:2] == `CMD_OFS >> 2) begin
				wr_word = merge(32'h0, state_reg.w_data, state_reg.w_strb);
				state_next.host_start  = wr_word[`CMD_START_BIT];
				state_next.host_pause  = wr_word[`CMD_PAUSE_BIT];
				state_next.host_halt   = wr_word[`CMD_HALT_BIT];
				state_next.host_rewind = wr_word[`CMD_REWIND_BIT];
			end else if (state_reg.aw_addr[ADDR_W-1:2] == `COUNT_OFS >> 2) begin
				wr_word = merge({{(32 - SW){1'b0}}, state_reg.step_count}, state_reg.w_data, state_reg.w_strb);
				// Out-of-range counts fall back to the full table so the step pointer can never run past it.
				if (wr_word == 32'h0 || wr_word > 32'(STEPS)) begin
					state_next.step_count = SW'(STEPS);
				end else begin
					state_next.step_count = SW'(wr_word);
				end
			end else if (is_step(state_reg.aw_addr)) begin
				wr_word = merge({state_reg.delays[wr_idx], 14'h0, state_reg.kinds[wr_idx]},
				                state_reg.w_data, state_reg.w_strb);
				state_next.kinds[wr_idx]  = batch_pkg::step_kind_t'(wr_word[`STEP_KIND_LSB +: 2]);
				state_next.delays[wr_idx] = wr_word[`STEP_DELAY_LSB +: 16];
			end else if (state_reg.aw_addr[ADDR_W-1:2] != `STATUS_OFS >> 2 &&
			             state_reg.aw_addr[ADDR_W-1:2] != `OUTS_OFS >> 2) begin
				state_next.bresp = `RESP_SLVERR;
			end
		end

		// Read side.
		if (araddr[ADDR_W-1:2] == `CTRL_OFS >> 2) begin
			rd_word = {30'h0, state_reg.permit_assigned, state_reg.manual};
		end else if (araddr[ADDR_W-1:2] == `CMD_OFS >> 2) begin
			rd_word = 32'h0;
		end else if (araddr[ADDR_W-1:2] == `COUNT_OFS >> 2) begin
			rd_word = {{(32 - SW){1'b0}}, state_reg.step_count};
		end else if (araddr[ADDR_W-1:2] == `STATUS_OFS >> 2) begin
			rd_word = {{(24 - SW){1'b0}}, state_reg.step, 5'h0, state_reg.run_state};
		end else if (araddr[ADDR_W-1:2] == `OUTS_OFS >> 2) begin
			rd_word = {{(32 - STEPS){1'b0}}, state_reg.outputs};
		end else if (is_step(araddr)) begin
			rd_word = {state_reg.delays[rd_idx], 14'h0, state_reg.kinds[rd_idx]};
		end else begin
			rd_ok = 1'b0;
		end
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		if (arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rdata  = rd_word;
			state_next.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Run control, highest priority first.
		if (!state_reg.manual) begin
			state_next.run_state = batch_pkg::ST_IDLE;
			state_next.step      = '0;
		end else if (rewind_req) begin
			state_next.run_state   = batch_pkg::ST_IDLE;
			state_next.step        = '0;
			state_next.delay_count = '0;
		end else if (halt_req) begin
			if (active) begin
				state_next.run_state = batch_pkg::ST_HALTED;
			end
		end else if (active && !permit_ok) begin
			state_next.run_state = batch_pkg::ST_HALTED;
		end else if (state_reg.host_pause && (state_reg.run_state == batch_pkg::ST_RUN ||
		                                      state_reg.run_state == batch_pkg::ST_HOLD_PIN)) begin
			state_next.run_state = batch_pkg::ST_HOLD_HOST;
		end else if (pause_pin) begin
			if (state_reg.run_state == batch_pkg::ST_RUN) begin
				state_next.run_state = batch_pkg::ST_HOLD_PIN;
			end
		end else if (state_reg.run_state == batch_pkg::ST_HOLD_PIN) begin
			state_next.run_state = batch_pkg::ST_RUN;
		end else if (start_req) begin
			if (!permit_ok) begin
				state_next.run_state   = batch_pkg::ST_IDLE;
				state_next.step        = '0;
				state_next.delay_count = '0;
			end else begin
				case (state_reg.run_state)
					batch_pkg::ST_IDLE, batch_pkg::ST_DONE: begin
						state_next.run_state   = batch_pkg::ST_RUN;
						state_next.step        = '0;
						state_next.delay_count = '0;
					end
					batch_pkg::ST_HALTED, batch_pkg::ST_HOLD_HOST: begin
						state_next.run_state = batch_pkg::ST_RUN;
					end
					batch_pkg::ST_RUN: begin
						advance = (cur_kind == batch_pkg::KIND_PAUSE);
					end
					default: begin
						state_next.run_state = state_reg.run_state;
					end
				endcase
			end
		end else if (state_reg.run_state == batch_pkg::ST_RUN) begin
			case (cur_kind)
				batch_pkg::KIND_LEVEL: advance = step_condition_met[state_reg.step];
				batch_pkg::KIND_DELAY: begin
					if (state_reg.delay_count >= state_reg.delays[state_reg.step]) begin
						advance = 1'b1;
					end else if (tick) begin
						state_next.delay_count = state_reg.delay_count + 16'h1;
					end
				end
				batch_pkg::KIND_SKIP: advance = 1'b1;
				default: advance = 1'b0;
			endcase
		end

		if (advance) begin
			state_next.delay_count = '0;
			if (state_reg.step == state_reg.step_count - SW'(1)) begin
				state_next.run_state = batch_pkg::ST_DONE;
				state_next.step      = '0;
			end else begin
				state_next.step = state_reg.step + SW'(1);
			end
		end

		// Only the running step drives its output; every halt, pause or finish forces all outputs off.
		for (int i = 0; i < STEPS; i++) begin
			state_next.outputs[i] = (state_next.run_state == batch_pkg::ST_RUN) &&
			                        (state_next.step == SW'(i)) &&
			                        (state_next.kinds[i] == batch_pkg::KIND_LEVEL);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg              <= '0;
			state_reg.manual          <= 1'(`CTRL_RESET >> `CTRL_MANUAL_BIT);
			state_reg.permit_assigned <= 1'(`CTRL_RESET >> `CTRL_PERMIT_BIT);
			state_reg.step_count   <= SW'(STEPS);
			state_reg.start_seen_n <= 1'b1;
			state_reg.key_seen_n   <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign awready       = !state_reg.aw_held;
	assign wready        = !state_reg.w_held;
	assign bvalid        = state_reg.bvalid;
	assign bresp         = state_reg.bresp;
	assign arready       = !state_reg.rvalid;
	assign rvalid        = state_reg.rvalid;
	assign rdata         = state_reg.rdata;
	assign rresp         = state_reg.rresp;
	assign batch_outputs = state_reg.outputs;
	assign run_state     = state_reg.run_state;

endmodule : batch_sequence_controller

// ===== tb/ops_panel.sv
// Operator side model: switches, keys and PLC contacts on the active-low control pins.
// Assumes its tasks are called from a bench process that runs on aclk.
module ops_panel (
	input  wire logic       aclk,
	output logic      [6:0] pins_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins idle high as pulled up; bit 0 is the permit contact and bit 1 the start switch.
	initial pins_n = 7'h7f;
	task automatic hold(input int i, input logic v);
		@(posedge aclk);
		pins_n[i] <= v;
	endtask : hold
	// A press lasts long enough to cross the input filter, so it is never lost as a glitch.
	task automatic press(input int i);
		hold(i, 1'b0);
		repeat (8) @(posedge aclk);
		hold(i, 1'b1);
	endtask : press
endmodule : ops_panel

// ===== tb/batch_ctrl_asserts.sv
// Assertions on the batch controller's run states, step outputs and register bus answers.
// Assumes it is bound into every controller instance and sees only its ports.
module batch_ctrl_asserts #(
	parameter int STEPS = 20
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             arvalid,
	input wire logic             arready,
	input wire logic             rvalid,
	input wire logic [1:0]       bresp,
	input wire logic             bvalid,
	input wire logic             bready,
	input wire logic             pause_hold_input_n,
	input wire logic             halt_request_input_n,
	input wire logic             rewind_request_input_n,
	input wire logic [STEPS-1:0] batch_outputs,
	input wire logic [2:0]       run_state
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	out_gate_a: assert property (run_state != batch_pkg::ST_RUN |-> batch_outputs == '0)
		else $error("step output on while not running");
	one_step_a: assert property ($onehot0(batch_outputs))
		else $error("more than one step output on");
	// Eight steady pin cycles cover the synchroniser and filter latency with margin.
	pause_hold_a: assert property ((!pause_hold_input_n) [*8] |=> run_state != batch_pkg::ST_RUN)
		else $error("running with pause pin held");
	pause_free_a: assert property (pause_hold_input_n [*8] |=> run_state != batch_pkg::ST_HOLD_PIN)
		else $error("still held after pause pin released");
	halt_stops_a: assert property ((!halt_request_input_n) [*8] |=>
		run_state inside {batch_pkg::ST_IDLE, batch_pkg::ST_HALTED, batch_pkg::ST_DONE})
		else $error("active with halt pin held");
	rewind_idle_a: assert property ((!rewind_request_input_n) [*8] |=> run_state == batch_pkg::ST_IDLE)
		else $error("not idle with rewind pin held");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
endmodule : batch_ctrl_asserts

bind batch_sequence_controller batch_ctrl_asserts #(.STEPS(STEPS)) chk_i (
	.aclk, .aresetn, .arvalid, .arready, .rvalid, .bresp, .bvalid, .bready, .pause_hold_input_n,
	.halt_request_input_n, .rewind_request_input_n, .batch_outputs, .run_state);

// ===== tb/tb_top.sv
// Self-checking bench for the batch controller: AXI4-Lite master, operator model and result monitor.
// Assumes the controller defaults apart from a ten-cycle tenth tick to keep delay steps short.
`include "batch_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [19:0] cond;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rnd;
	logic [19:0] outs;
	logic [2:0]  run_state;
	logic [33:0] rx;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	wire  [6:0]  pins_n;
	int          failures = 0, n_tests = 0, waited;

	batch_sequence_controller #(.TENTH_CYCLES(10)) dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.run_permit_input_n(pins_n[0]), .start_request_input_n(pins_n[1]), .pause_hold_input_n(pins_n[2]),
		.halt_request_input_n(pins_n[3]), .rewind_request_input_n(pins_n[4]), .panel_start_key_n(pins_n[5]),
		.panel_halt_key_n(pins_n[6]), .step_condition_met(cond), .batch_outputs(outs), .run_state);
	ops_panel pnl (.aclk, .pins_n);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic results();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	task automatic hang();
		failures++;
		results();
	endtask : hang
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_data
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_data({30'h0, got}, {30'h0, exp});
	endtask : cmp_resp

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY,
	                  input logic [3:0] s = 4'hf);
		int n = 0;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 100);
		bready <= 1'b0;
		if (n >= 100)
			hang();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
		int n = 0;
		@(posedge aclk);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 100);
		rready <= 1'b0;
		if (n >= 100)
			hang();
	endtask : rd
	// Waits for the state and outputs together, then checks the step through the status word.
	task automatic chk(input logic [2:0] s, input logic [4:0] stp, input logic [19:0] o);
		waited = 0;
		while ((run_state !== s || outs !== o) && waited < 300) begin
			@(posedge aclk);
			waited++;
		end
		if (waited >= 300)
			hang();
		rd(`STATUS_OFS, {19'h0, stp, 5'h0, s});
		rd(`OUTS_OFS, {12'h0, o});
	endtask : chk

	always @(posedge aclk) begin
		if (bvalid && bready)
			cmp_resp(bresp, bq.pop_front());
		if (rvalid && rready) begin
			rx = rq.pop_front();
			cmp_data(rdata, rx[31:0]);
			cmp_resp(rresp, rx[33:32]);
		end
	end

	initial begin
		#400000;
		hang();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= '0;
		{awaddr, araddr, wdata, wstrb, cond} <= '0;
		void'($urandom(68));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CTRL_OFS, 32'h0);
		rd(`COUNT_OFS, 32'h14);
		rd(8'h20, 32'h0, `RESP_SLVERR);
		wr(8'h20, 32'h1, `RESP_SLVERR);
		wr(`STATUS_OFS, 32'h5);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		rnd = $urandom();
		wr(`STEP_OFS + 8'h0c, rnd);
		rd(`STEP_OFS + 8'h0c, rnd & 32'hffff0003);
		// Upper bytes only: the kind field must survive a partial write.
		wr(`STEP_OFS + 8'h0c, ~rnd, `RESP_OKAY, 4'hc);
		rd(`STEP_OFS + 8'h0c, {~rnd[31:16], 14'h0, rnd[1:0]});
		wr(`COUNT_OFS, 32'h0);
		rd(`COUNT_OFS, 32'h14);
		wr(`COUNT_OFS, 32'h3);
		wr(`STEP_OFS + 8'h04, 32'h1);
		rnd = $urandom_range(3, 1);
		wr(`STEP_OFS + 8'h08, {rnd[15:0], 16'h0002});
		pnl.press(1);
		repeat (20) @(posedge aclk);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		wr(`CTRL_OFS, 32'h1);
		wr(`CMD_OFS, 32'h8);
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		cond <= 20'h1;
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		repeat (20) @(posedge aclk);
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		pnl.press(5);
		chk(batch_pkg::ST_DONE, 5'h0, 20'h0);
		cond <= 20'h0;
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		pnl.hold(2, 1'b0);
		chk(batch_pkg::ST_HOLD_PIN, 5'h0, 20'h0);
		pnl.hold(2, 1'b1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		wr(`CMD_OFS, 32'h2);
		chk(batch_pkg::ST_HOLD_HOST, 5'h0, 20'h0);
		repeat (20) @(posedge aclk);
		chk(batch_pkg::ST_HOLD_HOST, 5'h0, 20'h0);
		wr(`CMD_OFS, 32'h1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		cond <= 20'h1;
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		pnl.hold(3, 1'b0);
		chk(batch_pkg::ST_HALTED, 5'h1, 20'h0);
		pnl.hold(3, 1'b1);
		repeat (8) @(posedge aclk);
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		wr(`CMD_OFS, 32'h4);
		chk(batch_pkg::ST_HALTED, 5'h1, 20'h0);
		pnl.press(5);
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		pnl.press(6);
		chk(batch_pkg::ST_HALTED, 5'h1, 20'h0);
		wr(`CMD_OFS, 32'h1);
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		pnl.press(4);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		cond <= 20'h0;
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		cond <= 20'h1;
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		wr(`CMD_OFS, 32'h8);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		cond <= 20'h0;
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		@(posedge aclk);
		pnl.pins_n[3] <= 1'b0;
		pnl.pins_n[2] <= 1'b0;
		chk(batch_pkg::ST_HALTED, 5'h0, 20'h0);
		pnl.pins_n[4] <= 1'b0;
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		pnl.pins_n <= 7'h7f;
		repeat (8) @(posedge aclk);
		wr(`CTRL_OFS, 32'h3);
		pnl.press(1);
		repeat (20) @(posedge aclk);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		pnl.hold(0, 1'b0);
		repeat (8) @(posedge aclk);
		pnl.press(1);
		chk(batch_pkg::ST_RUN, 5'h0, 20'h1);
		cond <= 20'h1;
		chk(batch_pkg::ST_RUN, 5'h1, 20'h0);
		pnl.hold(0, 1'b1);
		chk(batch_pkg::ST_HALTED, 5'h1, 20'h0);
		pnl.press(1);
		chk(batch_pkg::ST_IDLE, 5'h0, 20'h0);
		results();
	end
endmodule : tb_top
